// ### lmac_addr_cycle.v
`timescale 1ns/10ps
`default_nettype none
`include "lmac_defines.vh"

module lmac_addr_cycle #(
  parameter [1:0] MODE_RESET = `LMAC_MODE_RESET
) (
  input wire CLK_I,
  input wire RST_N_I,
  input wire CYC_REQ_I,
  input wire [`LMAC_ADDR_W-1:0] CYC_ADDR_I,
  input wire CYC_HALF_I,
  input wire [`LMAC_CODE_W-1:0] CYC_CODE_I,
  input wire CYC_WR_I,
  input wire [`LMAC_BUS_W-1:0] CYC_WDATA_I,
  input wire VEC_LOAD_I,
  input wire [3:0] VEC_DATA_I,
  input wire CFG_WR_I,
  input wire [1:0] CFG_MODE_I,
  input wire COLUMN_MAP_SELECT_I,
  input wire [`LMAC_BUS_W-1:0] LOCAL_ADDR_DATA_BUS_I,
  output wire [`LMAC_BUS_W-1:0] LOCAL_ADDR_DATA_BUS_O,
  output wire LOCAL_ADDR_DATA_BUS_OE_O,
  output wire ADDR_LATCH_STROBE_O,
  output wire ROW_STROBE_N_O,
  output wire COL_STROBE_N_O,
  output wire [`LMAC_RCA_W-1:0] ROW_COL_ADDR_BUS_O,
  output wire [`LMAC_BANK_W-1:0] BANK_SEL_O,
  output wire [1:0] ROWCOL_MODE_O,
  output wire COL_MAP_SAMPLED_O,
  output wire [1:0] CYC_CLASS_O,
  output wire CYC_BUSY_O,
  output wire CYC_DONE_O,
  output wire CYC_REJECT_O,
  output wire [`LMAC_BUS_W-1:0] RD_DATA_O,
  output wire RD_VALID_O
);

  // ====================================================
  // States
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [1:0] q_r;
  reg [1:0] q_nxt;

  // ====================================================
  // Cycle holding registers
  reg [`LMAC_ADDR_W-1:0] addr_r;
  reg half_r;
  reg wr_r;
  reg [`LMAC_BUS_W-1:0] wdata_r;
  reg [1:0] mode_r;
  reg [1:0] cyc_mode_r;
  reg map_sel_r;

  // ====================================================
  // Output registers
  reg [`LMAC_BUS_W-1:0] lad_r;
  reg lad_oe_r;
  reg addr_latch_strobe_r;
  reg row_n_r;
  reg col_n_r;
  reg [`LMAC_RCA_W-1:0] rca_r;
  reg [`LMAC_BANK_W-1:0] bank_r;
  reg [1:0] class_r;
  reg busy_r;
  reg done_r;
  reg reject_r;
  reg [`LMAC_BUS_W-1:0] rd_data_r;
  reg rd_valid_r;

  // ====================================================
  // Pin synchronisers
  reg map_s1_r;
  reg map_s2_r;
  reg [`LMAC_BUS_W-1:0] lad_s1_r;
  reg [`LMAC_BUS_W-1:0] lad_s2_r;

  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      map_s1_r <= 1'b0;
      map_s2_r <= 1'b0;
      lad_s1_r <= {`LMAC_BUS_W{1'b0}};
      lad_s2_r <= {`LMAC_BUS_W{1'b0}};
    end else begin
      map_s1_r <= COLUMN_MAP_SELECT_I;
      map_s2_r <= map_s1_r;
      lad_s1_r <= LOCAL_ADDR_DATA_BUS_I;
      lad_s2_r <= lad_s1_r;
    end
  end

  // ====================================================
  // Phase decode
  // Every strobe event is one state and one quarter phase
  function phase_hit;
    input in_state;
    input [1:0] q;
    input [1:0] want_q;
    begin
      phase_hit = in_state && (q == want_q);
    end
  endfunction

  // ====================================================
  // Request qualification
  wire in_idle = (state_r == ST_IDLE);
  wire in_addr = (state_r == ST_ADDR);
  wire in_data = (state_r == ST_DATA);
  // (R18) reserved code never goes out
  wire req_bad = in_idle && CYC_REQ_I && (CYC_CODE_I == `LMAC_CODE_RESERVED);
  wire req_ok = in_idle && CYC_REQ_I && (CYC_CODE_I != `LMAC_CODE_RESERVED);
  wire map_take = phase_hit(in_addr, q_r, `LMAC_MAP_SAMPLE_Q);
  wire cyc_end = phase_hit(in_data, q_r, `LMAC_END_Q);
  wire addr_latch_strobe_fall = phase_hit(in_addr, q_r, `LMAC_ADDR_LATCH_STROBE_FALL_Q);
  wire row_fall = phase_hit(in_addr, q_r, `LMAC_ROW_FALL_Q);
  wire col_fall = phase_hit(in_data, q_r, `LMAC_COL_FALL_Q);

  // ====================================================
  // Mapper inputs
  // Idle presents the incoming request so the row is ready at once
  wire [`LMAC_BUS_W-1:0] req_laddr = {CYC_ADDR_I, CYC_HALF_I, 4'h0};
  wire [`LMAC_BUS_W-1:0] cyc_laddr = {addr_r, half_r, 4'h0};
  wire [`LMAC_BUS_W-1:0] map_laddr = in_idle ? req_laddr : cyc_laddr;
  wire [1:0] map_mode = in_idle ? mode_r : cyc_mode_r;
  // Sampled select feeds the column in the same edge
  wire map_sel = map_take ? map_s2_r : map_sel_r;
  wire [`LMAC_RCA_W-1:0] map_rca;
  wire [`LMAC_BANK_W-1:0] map_bank;

  // (R7) mode and select drive mapping
  lmac_rca_map u_map (
    .mode_i(map_mode),
    .map_sel_i(map_sel),
    .col_i(map_take),
    .laddr_i(map_laddr),
    .rca_o(map_rca),
    .bank_o(map_bank)
  );

  // ====================================================
  // Class decode
  function [1:0] code_class;
    input [`LMAC_CODE_W-1:0] code;
    begin
      // (R16) (R17) (R18) class by top bits
      if (code[3]) begin
        code_class = `LMAC_CLASS_CPU;
      end else if (code[2]) begin
        code_class = `LMAC_CLASS_VRAM;
      end else begin
        code_class = `LMAC_CLASS_OTHER;
      end
    end
  endfunction

  // ====================================================
  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    q_nxt = q_r + 2'h1;
    case (state_r)
      ST_IDLE: begin
        q_nxt = `LMAC_Q1;
        if (req_ok) begin
          state_nxt = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (q_r == `LMAC_Q4) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (q_r == `LMAC_Q4) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        q_nxt = `LMAC_Q1;
      end
    endcase
  end

  // ====================================================
  // Mode bits
  // Software may change the mode at any time; a cycle keeps its copy
  // (R9) two bits pick array size
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      mode_r <= MODE_RESET;
    // (R19) reset vector loads mode
    end else if (VEC_LOAD_I) begin
      mode_r <= {VEC_DATA_I[`LMAC_VEC_MODE1_BIT], VEC_DATA_I[`LMAC_VEC_MODE0_BIT]};
    end else if (CFG_WR_I) begin
      mode_r <= CFG_MODE_I;
    end
  end

  // ====================================================
  // Cycle registers
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_r <= ST_IDLE;
      q_r <= `LMAC_Q1;
      addr_r <= {`LMAC_ADDR_W{1'b0}};
      half_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= {`LMAC_BUS_W{1'b0}};
      cyc_mode_r <= `LMAC_MODE_RESET;
      map_sel_r <= 1'b0;
      lad_r <= {`LMAC_BUS_W{1'b0}};
      lad_oe_r <= 1'b0;
      rca_r <= {`LMAC_RCA_W{1'b0}};
      bank_r <= {`LMAC_BANK_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      q_r <= q_nxt;
      if (req_ok) begin
        addr_r <= CYC_ADDR_I;
        half_r <= CYC_HALF_I;
        wr_r <= CYC_WR_I;
        wdata_r <= CYC_WDATA_I;
        // (R21) mode frozen per cycle
        cyc_mode_r <= mode_r;
        // (R1) (R4) (R5) (R6) (R15) address word
        lad_r <= {CYC_ADDR_I, CYC_HALF_I, CYC_CODE_I};
        lad_oe_r <= 1'b1;
        // (R1) row address out
        rca_r <= map_rca;
        bank_r <= map_bank;
      end
      if (map_take) begin
        // (R8) select sampled in Q4
        map_sel_r <= map_s2_r;
        // (R3) column address out
        rca_r <= map_rca;
        // (R3) bus turns to data
        lad_r <= wdata_r;
        lad_oe_r <= wr_r;
      end
      if (cyc_end) begin
        lad_oe_r <= 1'b0;
      end
    end
  end

  // ====================================================
  // Cycle status
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      class_r <= `LMAC_CLASS_OTHER;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      reject_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      // (R18) reserved code refused
      reject_r <= req_bad;
      if (req_ok) begin
        class_r <= code_class(CYC_CODE_I);
        busy_r <= 1'b1;
      end
      if (cyc_end) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  // ====================================================
  // Strobe registers
  // Each strobe has a single owner, so no two edges can fight
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      addr_latch_strobe_r <= 1'b0;
      row_n_r <= 1'b1;
      col_n_r <= 1'b1;
    end else begin
      // (R2) latch strobe up
      if (req_ok) begin
        addr_latch_strobe_r <= 1'b1;
      // (R15) code valid at strobe fall
      end else if (addr_latch_strobe_fall) begin
        addr_latch_strobe_r <= 1'b0;
      end
      // (R2) row strobe falls
      if (row_fall) begin
        row_n_r <= 1'b0;
      end else if (cyc_end) begin
        row_n_r <= 1'b1;
      end
      // (R3) column strobe falls
      if (col_fall) begin
        col_n_r <= 1'b0;
      end else if (cyc_end) begin
        col_n_r <= 1'b1;
      end
    end
  end

  // ====================================================
  // Read data
  // Bus pin passes two flip-flops, so the word is two edges old
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rd_data_r <= {`LMAC_BUS_W{1'b0}};
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      // (R3) read word taken
      if (cyc_end && !wr_r) begin
        rd_data_r <= lad_s2_r;
        rd_valid_r <= 1'b1;
      end
    end
  end

  // ====================================================
  // Outputs
  assign LOCAL_ADDR_DATA_BUS_O = lad_r;
  assign LOCAL_ADDR_DATA_BUS_OE_O = lad_oe_r;
  assign ADDR_LATCH_STROBE_O = addr_latch_strobe_r;
  assign ROW_STROBE_N_O = row_n_r;
  assign COL_STROBE_N_O = col_n_r;
  assign ROW_COL_ADDR_BUS_O = rca_r;
  assign BANK_SEL_O = bank_r;
  assign ROWCOL_MODE_O = mode_r;
  assign COL_MAP_SAMPLED_O = map_sel_r;
  assign CYC_CLASS_O = class_r;
  assign CYC_BUSY_O = busy_r;
  assign CYC_DONE_O = done_r;
  assign CYC_REJECT_O = reject_r;
  assign RD_DATA_O = rd_data_r;
  assign RD_VALID_O = rd_valid_r;

endmodule // lmac_addr_cycle
`default_nettype wire

// ### lmac_addr_cycle_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmac_defines.vh"
module lmac_addr_cycle_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CYC_REQ_I,
  input wire logic [3:0] CYC_CODE_I,
  input wire logic VEC_LOAD_I,
  input wire logic [3:0] VEC_DATA_I,
  input wire logic [31:0] LOCAL_ADDR_DATA_BUS_O,
  input wire logic LOCAL_ADDR_DATA_BUS_OE_O,
  input wire logic ADDR_LATCH_STROBE_O,
  input wire logic ROW_STROBE_N_O,
  input wire logic COL_STROBE_N_O,
  input wire logic [12:0] ROW_COL_ADDR_BUS_O,
  input wire logic [1:0] ROWCOL_MODE_O,
  input wire logic COL_MAP_SAMPLED_O,
  input wire logic CYC_BUSY_O,
  input wire logic CYC_DONE_O,
  input wire logic CYC_REJECT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ==========================================
  // Helpers
  logic [31:0] addr_q;
  logic [31:0] row_sh;
  logic [1:0] vec_mode;
  logic [1:0] mode_q;
  // Row is mapped with the mode held before the take edge
  assign row_sh = LOCAL_ADDR_DATA_BUS_O >> (12 + mode_q);
  assign vec_mode = VEC_DATA_I[2:1];
  // Bus turns to data later, so keep the address word
  always @(posedge CLK_I) begin
    mode_q <= ROWCOL_MODE_O;
    if (ADDR_LATCH_STROBE_O) begin
      addr_q <= LOCAL_ADDR_DATA_BUS_O;
    end
  end
  // ==========================================
  // Properties
  property p_start;
    $rose(CYC_BUSY_O) |-> ADDR_LATCH_STROBE_O && LOCAL_ADDR_DATA_BUS_OE_O;
  endproperty
  a_start: assert property (p_start)
    else $error("cycle start without address drive");
  property p_code;
    ADDR_LATCH_STROBE_O |-> LOCAL_ADDR_DATA_BUS_O[3:0] == $past(CYC_CODE_I);
  endproperty
  a_code: assert property (p_code)
    else $error("cycle code wrong on bus");
  property p_latch;
    $rose(ADDR_LATCH_STROBE_O) |=> !ADDR_LATCH_STROBE_O ##1 $fell(ROW_STROBE_N_O);
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch or row strobe timing wrong");
  property p_col;
    $fell(ROW_STROBE_N_O) |-> ##3 $fell(COL_STROBE_N_O);
  endproperty
  a_col: assert property (p_col)
    else $error("column strobe timing wrong");
  property p_done;
    $rose(CYC_BUSY_O) |-> CYC_BUSY_O[*8] ##1 (CYC_DONE_O && !CYC_BUSY_O);
  endproperty
  a_done: assert property (p_done)
    else $error("cycle length wrong");
  property p_rsvd;
    !CYC_BUSY_O && !CYC_DONE_O && CYC_REQ_I && CYC_CODE_I == 4'hf
      |=> CYC_REJECT_O && !CYC_BUSY_O;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved code not refused");
  property p_vec;
    VEC_LOAD_I |=> ROWCOL_MODE_O == $past(vec_mode);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector load gave wrong mode");
  property p_row;
    $rose(ADDR_LATCH_STROBE_O) |-> ROW_COL_ADDR_BUS_O == row_sh[12:0];
  endproperty
  a_row: assert property (p_row)
    else $error("row address wrong");
  property p_col0;
    $fell(COL_STROBE_N_O) && !COL_MAP_SAMPLED_O |-> ROW_COL_ADDR_BUS_O == addr_q[16:4];
  endproperty
  a_col0: assert property (p_col0)
    else $error("column address wrong");
endmodule // lmac_addr_cycle_chk
bind lmac_addr_cycle lmac_addr_cycle_chk i_lmac_addr_cycle_chk (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .CYC_REQ_I(CYC_REQ_I), .CYC_CODE_I(CYC_CODE_I),
  .VEC_LOAD_I(VEC_LOAD_I), .VEC_DATA_I(VEC_DATA_I),
  .LOCAL_ADDR_DATA_BUS_O(LOCAL_ADDR_DATA_BUS_O), .LOCAL_ADDR_DATA_BUS_OE_O(LOCAL_ADDR_DATA_BUS_OE_O),
  .ADDR_LATCH_STROBE_O(ADDR_LATCH_STROBE_O), .ROW_STROBE_N_O(ROW_STROBE_N_O),
  .COL_STROBE_N_O(COL_STROBE_N_O), .ROW_COL_ADDR_BUS_O(ROW_COL_ADDR_BUS_O),
  .ROWCOL_MODE_O(ROWCOL_MODE_O), .COL_MAP_SAMPLED_O(COL_MAP_SAMPLED_O),
  .CYC_BUSY_O(CYC_BUSY_O), .CYC_DONE_O(CYC_DONE_O), .CYC_REJECT_O(CYC_REJECT_O));
`default_nettype wire

// ### lmac_addr_cycle_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmac_defines.vh"
module lmac_addr_cycle_tb_top;
  logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, half = 1'b0, wr = 1'b0;
  logic vld = 1'b0, cfg = 1'b0, sel = 1'b0;
  logic [26:0] addr = 27'h0;
  logic [3:0] code = 4'h0, vdat = 4'h0;
  logic [1:0] cmode = 2'h0;
  logic [31:0] wdat = 32'h0;
  wire [31:0] bus_in, bus_o, rd_data;
  wire oe, latch, row_n, col_n, busy, done, rej, rd_v, csamp;
  wire [12:0] rca;
  wire [3:0] bank;
  wire [1:0] mode, cls;
  integer error_cnt = 0, checked = 0, cyc_cnt = 0, i;
  always #10 clk = ~clk;
  lmac_addr_cycle i_lmac_addr_cycle (.CLK_I(clk), .RST_N_I(rst_n), .CYC_REQ_I(req),
    .CYC_ADDR_I(addr), .CYC_HALF_I(half), .CYC_CODE_I(code), .CYC_WR_I(wr),
    .CYC_WDATA_I(wdat), .VEC_LOAD_I(vld), .VEC_DATA_I(vdat), .CFG_WR_I(cfg),
    .CFG_MODE_I(cmode), .COLUMN_MAP_SELECT_I(sel), .LOCAL_ADDR_DATA_BUS_I(bus_in),
    .LOCAL_ADDR_DATA_BUS_O(bus_o), .LOCAL_ADDR_DATA_BUS_OE_O(oe),
    .ADDR_LATCH_STROBE_O(latch), .ROW_STROBE_N_O(row_n), .COL_STROBE_N_O(col_n),
    .ROW_COL_ADDR_BUS_O(rca), .BANK_SEL_O(bank), .ROWCOL_MODE_O(mode),
    .COL_MAP_SAMPLED_O(csamp), .CYC_CLASS_O(cls), .CYC_BUSY_O(busy), .CYC_DONE_O(done),
    .CYC_REJECT_O(rej), .RD_DATA_O(rd_data), .RD_VALID_O(rd_v));
  lmac_mem_model i_lmac_mem_model (.clk_i(clk), .oe_i(oe), .dev_d_i(bus_o),
    .latch_i(latch), .row_n_i(row_n), .col_n_i(col_n), .bus_o(bus_in));
  // ==========================================
  // Checking and closing
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task give_verdict;
    $display("Counts: %0d compared, %0d mismatched", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt = cyc_cnt + 1;
    if (cyc_cnt == 2000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  function automatic [12:0] col_exp(input [1:0] m, input s, input [31:0] l);
    integer n;
    for (n = 0; n < 13; n++) col_exp[n] = s ? l[n+3] : l[n+4];
    if (s) begin
      case (m)
        2'h0: {col_exp[12], col_exp[11], col_exp[0]} = {l[23], l[22], l[4]};
        2'h1: {col_exp[12], col_exp[11], col_exp[0]} = {l[26], l[14], l[4]};
        2'h2: {col_exp[12], col_exp[11], col_exp[0]} = {l[15], l[14], l[4]};
        default: {col_exp[12], col_exp[11], col_exp[0]} = {l[28], l[14], l[16]};
      endcase
    end
  endfunction
  // ==========================================
  // One memory cycle with mode load before it
  task run_cyc(input [1:0] m, input s, input [26:0] a, input h, input [3:0] c, input w);
    logic [31:0] l;
    l = {a, h, 4'h0};
    @(posedge clk) #1;
    sel = s; cfg = 1'b1; cmode = m;
    @(posedge clk) #1;
    cfg = 1'b0; req = 1'b1; addr = a; half = h; code = c; wr = w;
    wdat = {a[15:0], 16'hc3a5};
    chk("mode", m, mode);
    @(posedge clk) #1;
    req = 1'b0; cfg = 1'b1; cmode = ~m;
    chk("addr word", {a, h, c}, bus_o);
    chk("drive", 2'h3, {oe, latch});
    chk("row", (l >> (12 + m)) & 32'h1fff, rca);
    chk("bank", (l >> (20 + 2 * m)) & ((32'h10 >> m) - 1), bank);
    chk("class", c[3] ? 2'h2 : {1'b0, c[2]}, cls);
    @(posedge clk) #1;
    cfg = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("col strobe", 1'b0, col_n);
    chk("column", col_exp(m, s, l), rca);
    chk("select", s, csamp);
    if (w) chk("wdata", wdat, bus_o);
    chk("data drive", w, oe);
    repeat (3) @(posedge clk);
    #1;
    chk("end", 3'h5, {done, busy, row_n});
    if (!w) chk("rdata", ~{a, h, c}, rd_data);
    chk("rd valid", !w, rd_v);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset", 4'h2, {oe, latch, row_n, busy});
    chk("reset mode", 2'h0, mode);
    $display("reset test done");
    @(posedge clk) #1;
    vld = 1'b1; cfg = 1'b1; vdat = 4'h4; cmode = 2'h1;
    @(posedge clk) #1;
    vld = 1'b0; cfg = 1'b0;
    chk("vector mode", 2'h2, mode);
    $display("mode load test done");
    for (i = 0; i < 15; i++) begin
      run_cyc(i[1:0], i[2], 27'h4d2b6e9 ^ (i[26:0] * 27'h0f12345), i[0], i[3:0], i[0]);
    end
    $display("cycle test done");
    @(posedge clk) #1;
    req = 1'b1; code = 4'hf;
    @(posedge clk) #1;
    req = 1'b0;
    chk("reserved", 2'h2, {rej, busy});
    $display("reserved test done");
    repeat (3) @(posedge clk);
    give_verdict;
  end
endmodule // lmac_addr_cycle_tb_top
`default_nettype wire

// ### lmac_defines.vh
`ifndef LMAC_DEFINES_VH
`define LMAC_DEFINES_VH
// Functional notes
// (R1) Cycle start: address, code on bus, row out
// (R2) Address latch strobe and row strobe provided
// (R3) Then bus carries data, row/col bus column
// (R4) Bus line 31 is most significant bit
// (R5) Address field selects one of 128M long-words
// (R6) Half bit: 0 lower word, 1 upper word
// (R7) Row/col bits chosen by mode and map select
// (R8) Map select sampled on fourth quarter phase
// (R9) Modes 00..11 select 64K..4M addressing
// (R10) Mode gives 16, 8, 4, 2 banks
// (R11) Row time: line n carries bit n+12+mode
// (R12) Column, select 0: line n carries n+4
// (R13) 64K mode bits 12..16 output twice
// (R14) Column, select 1: lines 1..10 carry n+3
// (R15) Cycle code on lowest four bus lines
// (R16) Codes 00xx: other cycles class
// (R17) Codes 01xx: VRAM class
// (R18) Codes 1xxx: processor class, 1111 never issued
// (R19) Reset vector fetch loads mode bits
// (R20) Select 1 lines 0, 11, 12 per table
// (R21) Mode bits held constant within one cycle

// ====================================================
// Bus layout
`define LMAC_BUS_W 32
`define LMAC_RCA_W 13
`define LMAC_ADDR_W 27
`define LMAC_CODE_W 4
`define LMAC_HALF_BIT 4
`define LMAC_BANK_W 4

// ====================================================
// Address mapping bases
`define LMAC_ROW_BASE 12
`define LMAC_COL_BASE 4
`define LMAC_MAP1_BASE 3
`define LMAC_BANK_BASE 5'h14

// ====================================================
// Quarter phases and event timing
`define LMAC_Q1 2'h0
`define LMAC_Q2 2'h1
`define LMAC_Q3 2'h2
`define LMAC_Q4 2'h3
`define LMAC_ADDR_LATCH_STROBE_FALL_Q `LMAC_Q1
`define LMAC_ROW_FALL_Q `LMAC_Q2
`define LMAC_MAP_SAMPLE_Q `LMAC_Q4
`define LMAC_COL_FALL_Q `LMAC_Q1
`define LMAC_END_Q `LMAC_Q4

// ====================================================
// Cycle codes, classes, mode
`define LMAC_CODE_RESERVED 4'hf
`define LMAC_CLASS_OTHER 2'h0
`define LMAC_CLASS_VRAM 2'h1
`define LMAC_CLASS_CPU 2'h2
`define LMAC_MODE_64K 2'h0
`define LMAC_MODE_256K 2'h1
`define LMAC_MODE_1M 2'h2
`define LMAC_MODE_4M 2'h3
`define LMAC_MODE_RESET 2'h0
`define LMAC_VEC_MODE0_BIT 1
`define LMAC_VEC_MODE1_BIT 2
`endif

// ### lmac_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module lmac_mem_model (
  input wire logic clk_i,
  input wire logic oe_i,
  input wire logic [31:0] dev_d_i,
  input wire logic latch_i,
  input wire logic row_n_i,
  input wire logic col_n_i,
  output logic [31:0] bus_o
);
  logic [31:0] addr_r;
  logic [31:0] last_r;
  always @(posedge clk_i) begin
    if (latch_i) begin
      addr_r <= dev_d_i;
    end
    last_r <= bus_o;
  end
  // Released bus gives ~addr_r while both strobes are low, else toggles so stale data never looks valid
  assign bus_o = oe_i ? dev_d_i : (!row_n_i && !col_n_i) ? ~addr_r : ~last_r;
endmodule // lmac_mem_model
`default_nettype wire

// ### lmac_rca_map.v
`timescale 1ns/10ps
`default_nettype none
`include "lmac_defines.vh"

module lmac_rca_map (
  input wire [1:0] mode_i,
  input wire map_sel_i,
  input wire col_i,
  input wire [`LMAC_BUS_W-1:0] laddr_i,
  output reg [`LMAC_RCA_W-1:0] rca_o,
  output wire [`LMAC_BANK_W-1:0] bank_o
);

  integer n;
  wire [`LMAC_BUS_W-1:0] bank_sh;

  // ====================================================
  // Row and column line mapping
  always @* begin
    rca_o = {`LMAC_RCA_W{1'b0}};
    for (n = 0; n < `LMAC_RCA_W; n = n + 1) begin
      // (R11) row bits shift
      if (!col_i) begin
        rca_o[n] = laddr_i[n + `LMAC_ROW_BASE + mode_i];
      // (R12) (R13) plain column
      end else if (!map_sel_i) begin
        rca_o[n] = laddr_i[n + `LMAC_COL_BASE];
      // (R14) remapped column
      end else begin
        rca_o[n] = laddr_i[n + `LMAC_MAP1_BASE];
      end
    end
    // (R20) edge lines table
    if (col_i && map_sel_i) begin
      case (mode_i)
        `LMAC_MODE_64K: begin
          rca_o[0] = laddr_i[4];
          rca_o[11] = laddr_i[22];
          rca_o[12] = laddr_i[23];
        end
        `LMAC_MODE_256K: begin
          rca_o[0] = laddr_i[4];
          rca_o[11] = laddr_i[14];
          rca_o[12] = laddr_i[26];
        end
        `LMAC_MODE_1M: begin
          rca_o[0] = laddr_i[4];
          rca_o[11] = laddr_i[14];
          rca_o[12] = laddr_i[15];
        end
        default: begin
          rca_o[0] = laddr_i[16];
          rca_o[11] = laddr_i[14];
          rca_o[12] = laddr_i[28];
        end
      endcase
    end
  end

  // ====================================================
  // Bank select
  // (R10) bits just above row
  assign bank_sh = laddr_i >> (`LMAC_BANK_BASE + {2'h0, mode_i, 1'b0});
  assign bank_o = bank_sh[`LMAC_BANK_W-1:0] & (4'hf >> mode_i);

endmodule // lmac_rca_map
`default_nettype wire
